//--- rtl/ubf_pkg.sv
// ubf_pkg: constants shared by the serial port core and its baud generator
// assumes a single 10 MHz module clock and an 8-bit register port
package ubf_pkg;

	// module clock rate
	localparam int unsigned UBF_CLK_HZ = 10_000_000;

	// register indices on the 3-bit register port
	localparam logic [2:0] UBF_A_BAUD_HI = 3'h0;
	localparam logic [2:0] UBF_A_BAUD_LO = 3'h1;
	localparam logic [2:0] UBF_A_FRAC = 3'h2;
	localparam logic [2:0] UBF_A_CFG = 3'h3;
	localparam logic [2:0] UBF_A_CTL = 3'h4;
	localparam logic [2:0] UBF_A_DATA = 3'h5;
	localparam logic [2:0] UBF_A_STAT = 3'h6;

	// frame config register fields
	localparam int UBF_CFG_NINE = 0;
	localparam int UBF_CFG_PE = 1;
	localparam int UBF_CFG_ODD = 2;
	localparam int UBF_CFG_TENTH = 3;
	localparam int UBF_CFG_HIGH_BIT_FIRST_ORDER = 4;
	localparam int UBF_CFG_WRAP = 5;
	localparam int UBF_CFG_RX_INPUT_SELECT = 6;

	// control register fields
	localparam int UBF_CTL_TX_ON = 0;
	localparam int UBF_CTL_RX_ON = 1;
	localparam int UBF_CTL_TX_POLARITY_FLIP = 2;
	localparam int UBF_CTL_RX_POLARITY_FLIP = 3;
	localparam int UBF_CTL_IR_EN = 4;
	localparam int UBF_CTL_IR_W = 5;
	localparam int UBF_CTL_T8 = 7;

	// reset values
	localparam logic [7:0] UBF_CFG_RST = 8'h00;
	localparam logic [7:0] UBF_CTL_RST = 8'h00;
	localparam logic [12:0] UBF_DIV_RST = 13'h0000;
	localparam logic [4:0] UBF_FRAC_RST = 5'h00;

	// oversampling: samples per bit and the start-bit mid point
	localparam logic [3:0] UBF_SUB_LAST = 4'hF;
	localparam logic [3:0] UBF_SUB_MID = 4'h7;
	localparam logic [4:0] UBF_IR_STRETCH = 5'h10;

	// infrared pulse widths in 32nds of a bit, bit centre at 16/32
	localparam logic [4:0] UBF_IR_W_1_32 = 5'h01;
	localparam logic [4:0] UBF_IR_W_1_16 = 5'h02;
	localparam logic [4:0] UBF_IR_W_3_16 = 5'h06;
	localparam logic [4:0] UBF_IR_W_1_4 = 5'h08;
	localparam logic [4:0] UBF_IR_CENTRE = 5'h10;

	// infrared supported bit rates and matching divisor window
	localparam int unsigned UBF_IR_MIN_BPS = 2400;
	localparam int unsigned UBF_IR_MAX_BPS = 115200;
	localparam logic [12:0] UBF_IR_DIV_MIN = 13'((UBF_CLK_HZ
		+ 16 * UBF_IR_MAX_BPS - 1) / (16 * UBF_IR_MAX_BPS));
	localparam logic [12:0] UBF_IR_DIV_MAX =
		13'(UBF_CLK_HZ / (16 * UBF_IR_MIN_BPS));

	// receiver states, gray along idle-start-data-done
	typedef enum logic [1:0] {
		UBF_RX_IDLE = 2'b00,
		UBF_RX_START = 2'b01,
		UBF_RX_DATA = 2'b11,
		UBF_RX_DONE = 2'b10
	} ubf_rx_state_t;

endpackage : ubf_pkg

//--- rtl/ubf_baud.sv
// ubf_baud: integer plus fractional divider making the 16x sample tick
// assumes divisor and fraction are stable registers in the same clock domain
`timescale 1ns/1ns
module ubf_baud import ubf_pkg::*; #(
	parameter int DIV_W = 13,
	parameter int FRAC_W = 5
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic [FRAC_W-1:0] frac_code,
	output logic tick,
	output logic half
);

	logic [DIV_W:0] cnt_q; // cycles left in this tick period
	logic [FRAC_W-1:0] acc_q; // fractional accumulator
	logic [FRAC_W:0] acc_sum; // accumulator plus code, with carry
	logic running; // divisor nonzero

	// a zero divisor parks the generator [R07]
	assign running = (divisor != '0);
	assign acc_sum = {1'b0, acc_q} + {1'b0, frac_code};

	// tick closes each period; half marks its middle for ir timing
	assign tick = running && (cnt_q == '0); // [R05]
	assign half = running && (cnt_q != '0)
		&& (cnt_q == {2'b00, divisor[DIV_W-1:1]});

	// period is divisor, or divisor+1 when the fraction carries,
	// so the mean period is divisor + code/32 [R01] [R02] [R03] [R04]
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			acc_q <= '0;
		end else if (!running) begin
			cnt_q <= '0; // stopped [R07]
			acc_q <= '0;
		end else if (cnt_q == '0) begin
			acc_q <= acc_sum[FRAC_W-1:0]; // [R04]
			cnt_q <= {1'b0, divisor} - 1'b1
				+ {{DIV_W{1'b0}}, acc_sum[FRAC_W]}; // [R03]
		end else begin
			cnt_q <= cnt_q - 1'b1; // [R01]
		end
	end

endmodule : ubf_baud

//--- rtl/ubf_core.sv
// ubf_core: serial port with baud generator, framing, loop and infrared
// assumes a register master on the plain port and pins synchronous to clk
//
// Contract
// (R01) 13-bit integer plus 5-bit fractional baud divider
// (R02) integer divisor accepts 1 to 8191
// (R03) rate is clock over 16 times divisor
// (R04) fraction equals code over thirty-two
// (R05) baud tick drives receiver, 16 samples per bit
// (R06) transmitter advances one bit per sixteen ticks
// (R07) zero divisor stops; high byte waits low
// (R08) one start bit, data, one stop bit
// (R09) 8-bit mode gives 10-bit frames
// (R10) 8-bit parity replaces the eighth data bit
// (R11) nine-bit without tenth gives 11-bit frames
// (R12) transmit ninth bit persists across frames
// (R13) nine plus tenth gives 12-bit parity frames
// (R14) software sets tenth only with nine, parity
// (R15) software avoids address mark with parity
// (R16) data order low-first or high-first selectable
// (R17) wrap plus source feeds receiver from tx pin
// (R18) wrap alone feeds transmitter output to receiver
// (R19) software enables tx and rx for internal_wrap
// (R20) ir pulse centred in zero bits, four widths
// (R21) tx inversion selects high or low pulse
// (R22) ir decoder stretches pulses back into bits
// (R23) infrared supports 2.4 to 115.2 kbit/s only
// (R24) line idles high, start low, stop high
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module ubf_core import ubf_pkg::*; #(
	parameter int DIV_W = 13,
	parameter int FRAC_W = 5
) (
	core_clk,
	resetn,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	rxd_i,
	txd_i,
	txd_o,
	txd_oe_n,
	tx_busy,
	rx_valid,
	rx_data,
	rx_ninth_bit,
	rx_addr_mark,
	rx_frame_err,
	rx_parity_err
);
	input wire logic core_clk; // module clock
	input wire logic resetn; // async reset, active low
	input wire logic [2:0] reg_addr; // register index
	input wire logic [7:0] reg_wdata; // write data
	input wire logic reg_wr; // write strobe
	input wire logic reg_rd; // read strobe
	output logic [7:0] reg_rdata; // read data, cycle after strobe
	input wire logic rxd_i; // receive pin
	input wire logic txd_i; // transmit pin level as seen on the wire
	output logic txd_o; // transmit pin drive value
	output logic txd_oe_n; // transmit pin enable, low drives
	output logic tx_busy; // frame in flight
	output logic rx_valid; // one-cycle pulse, frame received
	output logic [7:0] rx_data; // low eight received data bits
	output logic rx_ninth_bit; // received ninth bit
	output logic rx_addr_mark; // bit just before the stop bit
	output logic rx_frame_err; // stop bit sampled low
	output logic rx_parity_err; // parity mismatch

	// data bits per frame: 8 or 9, less one when parity takes a slot
	function automatic logic [3:0] ubf_ndata(input logic nine,
		input logic pe, input logic tenth);
		return 4'h8 + {3'h0, nine} - {3'h0, pe & ~tenth};
	endfunction : ubf_ndata

	// build an lsb-out frame: start, data, optional parity, stop
	function automatic logic [11:0] ubf_pack(input logic [8:0] d,
		input logic [3:0] n, input logic pe, input logic odd,
		input logic high_bit_first_order);
		logic [11:0] f;
		logic par;
		logic b;
		f = 12'hFFF; // idle and stop are ones [R24]
		f[0] = 1'b0; // start bit [R08]
		par = odd;
		b = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				b = high_bit_first_order ? d[int'(n) - 1 - i] : d[i]; // [R16]
				f[i + 1] = b;
				par = par ^ b;
			end
		end
		if (pe) begin
			f[n + 4'h1] = par; // generated parity [R10] [R11] [R13]
		end
		return f;
	endfunction : ubf_pack

	// gather the received data bits back into natural order
	function automatic logic [8:0] ubf_unpack(input logic [10:0] r,
		input logic [3:0] n, input logic high_bit_first_order);
		logic [8:0] d;
		d = 9'h000;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n)) begin
				if (high_bit_first_order) begin
					d[int'(n) - 1 - i] = r[i]; // [R16]
				end else begin
					d[i] = r[i];
				end
			end
		end
		return d;
	endfunction : ubf_unpack

	logic [4:0] div_hi_q; // staged high divisor bits
	logic [12:0] div_q; // active integer divisor
	logic [4:0] frac_q; // fine adjust code
	logic [7:0] cfg_q; // frame and routing config
	logic [7:0] ctl_q; // enables, polarity, ir, ninth bit
	logic tick; // 16x sample tick
	logic half; // middle of a tick period
	logic [3:0] n_data; // data bits per frame
	logic pe; // parity enabled
	logic tx_on; // transmitter enable
	logic rx_on; // receiver enable
	logic ir_en; // infrared coding on
	logic tx_load; // accept a write to the data register

	assign pe = cfg_q[UBF_CFG_PE];
	assign tx_on = ctl_q[UBF_CTL_TX_ON];
	assign rx_on = ctl_q[UBF_CTL_RX_ON];
	assign ir_en = ctl_q[UBF_CTL_IR_EN];
	assign n_data = ubf_ndata(cfg_q[UBF_CFG_NINE], pe,
		cfg_q[UBF_CFG_TENTH]); // [R09] [R11] [R13]
	assign tx_load = reg_wr && (reg_addr == UBF_A_DATA) && tx_on
		&& !tx_busy;

	// software-written configuration; the high divisor byte is only
	// staged so a half-written divisor never runs [R07]
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			div_hi_q <= UBF_DIV_RST[12:8];
			div_q <= UBF_DIV_RST;
			frac_q <= UBF_FRAC_RST;
			cfg_q <= UBF_CFG_RST;
			ctl_q <= UBF_CTL_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				UBF_A_BAUD_HI: div_hi_q <= reg_wdata[4:0]; // [R07]
				UBF_A_BAUD_LO: div_q <= {div_hi_q, reg_wdata}; // [R02]
				UBF_A_FRAC: frac_q <= reg_wdata[4:0]; // [R04]
				UBF_A_CFG: cfg_q <= reg_wdata;
				UBF_A_CTL: ctl_q <= reg_wdata; // ninth bit kept [R12]
				default: ; // data writes handled elsewhere, status writes ignored
			endcase
		end
	end

	// shared divider for both directions [R01]
	ubf_baud #(
		.DIV_W(DIV_W),
		.FRAC_W(FRAC_W)
	) u_baud (
		.core_clk(core_clk),
		.resetn(resetn),
		.divisor(div_q),
		.frac_code(frac_q),
		.tick(tick),
		.half(half)
	);

	// ---------------- transmitter ----------------
	logic [11:0] tx_sh_q; // frame shift register, lsb on the line
	logic [3:0] tx_left_q; // bits still to send incl. current
	logic [3:0] tx_sub_q; // tick count within the bit
	logic tx_half_q; // second half of the current tick
	logic tx_busy_q; // frame in flight
	logic tx_bit; // raw nrz bit before coding
	logic [4:0] ir_w; // pulse width in 32nds
	logic [4:0] ir_lo; // pulse start in 32nds
	logic [4:0] tx_pos; // position within the bit in 32nds
	logic ir_win; // inside the centred pulse window
	logic tx_line; // coded line value before the pin flop
	logic txd_q; // pin flop
	logic oe_n_q; // pin enable flop

	assign tx_busy = tx_busy_q;

	// load a frame, then shift one bit per sixteen ticks [R06]
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_sh_q <= 12'hFFF;
			tx_left_q <= 4'h0;
			tx_sub_q <= 4'h0;
			tx_busy_q <= 1'b0;
		end else if (!tx_on) begin
			tx_sh_q <= 12'hFFF; // disabled line rests idle [R24]
			tx_left_q <= 4'h0;
			tx_sub_q <= 4'h0;
			tx_busy_q <= 1'b0;
		end else if (tx_load) begin
			// ninth bit comes from the control register [R12]
			tx_sh_q <= ubf_pack({ctl_q[UBF_CTL_T8], reg_wdata}, n_data,
				pe, cfg_q[UBF_CFG_ODD], cfg_q[UBF_CFG_HIGH_BIT_FIRST_ORDER]); // [R08]
			tx_left_q <= n_data + {3'h0, pe} + 4'h2; // [R09] [R11] [R13]
			tx_sub_q <= 4'h0;
			tx_busy_q <= 1'b1;
		end else if (tx_busy_q && tick) begin
			tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_sub_q == UBF_SUB_LAST) begin
				tx_sh_q <= {1'b1, tx_sh_q[11:1]}; // [R06]
				tx_left_q <= tx_left_q - 4'h1;
				if (tx_left_q == 4'h1) begin
					tx_busy_q <= 1'b0; // stop bit done
				end
			end
		end
	end

	// half-tick phase gives the 1/32 resolution of the narrow pulse
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_half_q <= 1'b0;
		end else if (tick || tx_load) begin
			tx_half_q <= 1'b0;
		end else if (half) begin
			tx_half_q <= 1'b1;
		end
	end

	// pulse width select [R20]
	always_comb begin
		case (ctl_q[UBF_CTL_IR_W +: 2])
			2'h0: ir_w = UBF_IR_W_1_32;
			2'h1: ir_w = UBF_IR_W_1_16;
			2'h2: ir_w = UBF_IR_W_3_16;
			2'h3: ir_w = UBF_IR_W_1_4;
			default: ir_w = UBF_IR_W_1_32;
		endcase
	end

	assign tx_bit = tx_busy_q ? tx_sh_q[0] : 1'b1; // idle high [R24]
	assign tx_pos = {tx_sub_q, tx_half_q};
	assign ir_lo = UBF_IR_CENTRE - {1'b0, ir_w[4:1]};
	// window is centred on the middle of the bit [R20]
	assign ir_win = (tx_pos >= ir_lo) && (tx_pos < ir_lo + ir_w);

	// pulse for a zero only, polarity by tx inversion [R20] [R21]
	always_comb begin
		if (ir_en) begin
			tx_line = (~tx_bit & ir_win & tx_busy_q)
				^ ctl_q[UBF_CTL_TX_POLARITY_FLIP]; // [R21]
		end else begin
			tx_line = tx_bit ^ ctl_q[UBF_CTL_TX_POLARITY_FLIP];
		end
	end

	// pin drive; single-wire releases the pin between frames so the
	// far end can talk, two-wire drives whenever enabled [R17]
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			txd_q <= 1'b1;
			oe_n_q <= 1'b1;
		end else begin
			txd_q <= tx_line;
			oe_n_q <= !(tx_on && (!(cfg_q[UBF_CFG_WRAP]
				&& cfg_q[UBF_CFG_RX_INPUT_SELECT]) || tx_busy_q)); // [R17]
		end
	end

	assign txd_o = txd_q;
	assign txd_oe_n = oe_n_q;

	// ---------------- receive source and ir decoder ----------------
	logic rx_src; // selected line before polarity
	logic rx_lvl; // line after polarity flip
	logic [4:0] ir_str_q; // ticks left of a stretched zero
	logic rx_bit; // bit stream into the receiver

	// wrap modes cut off the receive pin [R17] [R18]
	always_comb begin
		if (cfg_q[UBF_CFG_WRAP] && cfg_q[UBF_CFG_RX_INPUT_SELECT]) begin
			rx_src = txd_i; // single-wire from the tx pin [R17]
		end else if (cfg_q[UBF_CFG_WRAP]) begin
			rx_src = txd_q; // internal loop [R18]
		end else begin
			rx_src = rxd_i;
		end
	end

	assign rx_lvl = rx_src ^ ctl_q[UBF_CTL_RX_POLARITY_FLIP]; // [R22]

	// each detected pulse holds a zero for one bit time [R22]
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ir_str_q <= 5'h00;
		end else if (ir_en && rx_lvl) begin
			ir_str_q <= UBF_IR_STRETCH; // [R22]
		end else if (tick && ir_str_q != 5'h00) begin
			ir_str_q <= ir_str_q - 5'h01;
		end
	end

	// a pulse, or its stretch, is a zero; no pulse is a one [R22]
	assign rx_bit = ir_en ? !(rx_lvl || ir_str_q != 5'h00) : rx_lvl;

	// ---------------- receiver ----------------
	ubf_rx_state_t rx_st_q; // receiver state
	logic rx_prev_q; // last cycle's line, for the falling edge
	logic [3:0] rx_sub_q; // ticks within the bit
	logic [3:0] rx_idx_q; // bit index after start
	logic [10:0] rx_sh_q; // bits after the start bit
	logic [3:0] rx_last; // index of the stop bit
	logic [8:0] rx_d; // data in natural order
	logic rx_par; // recomputed parity
	logic rx_valid_q; // frame done pulse
	logic [7:0] rx_data_q; // received data
	logic rx_ninth_q; // received ninth bit
	logic rx_mark_q; // bit before stop
	logic rx_ferr_q; // framing error
	logic rx_perr_q; // parity error
	logic rx_full_q; // unread data present

	assign rx_last = n_data + {3'h0, pe}; // stop position [R08]
	assign rx_d = ubf_unpack(rx_sh_q, n_data, cfg_q[UBF_CFG_HIGH_BIT_FIRST_ORDER]);

	// parity over the data bits as they stood on the line
	always_comb begin
		rx_par = cfg_q[UBF_CFG_ODD];
		for (int i = 0; i < 9; i++) begin
			if (i < int'(n_data)) begin
				rx_par = rx_par ^ rx_sh_q[i];
			end
		end
	end

	// start on a falling edge, confirm at mid start, then sample
	// every sixteen ticks; a single mid sample keeps this small but
	// gives no noise voting [R05]
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_st_q <= UBF_RX_IDLE;
			rx_prev_q <= 1'b1;
			rx_sub_q <= 4'h0;
			rx_idx_q <= 4'h0;
			rx_sh_q <= 11'h7FF;
		end else begin
			rx_prev_q <= rx_bit;
			case (rx_st_q)
				UBF_RX_IDLE: begin
					rx_sub_q <= 4'h0;
					rx_idx_q <= 4'h0;
					if (rx_on && rx_prev_q && !rx_bit) begin
						rx_st_q <= UBF_RX_START; // [R24]
					end
				end
				UBF_RX_START: begin
					if (!rx_on) begin
						rx_st_q <= UBF_RX_IDLE;
					end else if (tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						if (rx_sub_q == UBF_SUB_MID) begin
							rx_sub_q <= 4'h0;
							// glitch shorter than half a bit
							rx_st_q <= rx_bit ? UBF_RX_IDLE
								: UBF_RX_DATA;
						end
					end
				end
				UBF_RX_DATA: begin
					if (!rx_on) begin
						rx_st_q <= UBF_RX_IDLE;
					end else if (tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						if (rx_sub_q == UBF_SUB_LAST) begin
							rx_sh_q[rx_idx_q] <= rx_bit; // [R05]
							rx_idx_q <= rx_idx_q + 4'h1;
							if (rx_idx_q == rx_last) begin
								rx_st_q <= UBF_RX_DONE;
							end
						end
					end
				end
				UBF_RX_DONE: rx_st_q <= UBF_RX_IDLE;
				default: rx_st_q <= UBF_RX_IDLE;
			endcase
		end
	end

	// publish a finished frame with its checks
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_valid_q <= 1'b0;
			rx_data_q <= 8'h00;
			rx_ninth_q <= 1'b0;
			rx_mark_q <= 1'b0;
			rx_ferr_q <= 1'b0;
			rx_perr_q <= 1'b0;
		end else begin
			rx_valid_q <= (rx_st_q == UBF_RX_DONE);
			if (rx_st_q == UBF_RX_DONE) begin
				rx_data_q <= rx_d[7:0]; // [R09]
				rx_ninth_q <= cfg_q[UBF_CFG_NINE] & rx_d[8]; // [R11]
				rx_mark_q <= rx_sh_q[rx_last - 4'h1]; // [R13]
				rx_ferr_q <= !rx_sh_q[rx_last]; // stop low [R08]
				rx_perr_q <= pe && (rx_par != rx_sh_q[n_data]); // [R10]
			end
		end
	end

	// unread flag: a new frame in the same cycle as the read wins
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_full_q <= 1'b0;
		end else if (rx_valid_q) begin
			rx_full_q <= 1'b1;
		end else if (reg_rd && reg_addr == UBF_A_DATA) begin
			rx_full_q <= 1'b0;
		end
	end

	assign rx_valid = rx_valid_q;
	assign rx_data = rx_data_q;
	assign rx_ninth_bit = rx_ninth_q;
	assign rx_addr_mark = rx_mark_q;
	assign rx_frame_err = rx_ferr_q;
	assign rx_parity_err = rx_perr_q;

	// ---------------- register read ----------------
	logic ir_rate_ok; // divisor inside the infrared rate window
	logic [7:0] rdata_q; // read data flop

	// infrared coding is only specified for this divisor span [R23]
	assign ir_rate_ok = (div_q >= UBF_IR_DIV_MIN)
		&& (div_q <= UBF_IR_DIV_MAX); // [R23]

	// read data stand in the cycle after the strobe only
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				UBF_A_BAUD_HI: rdata_q <= {3'h0, div_q[12:8]};
				UBF_A_BAUD_LO: rdata_q <= div_q[7:0];
				UBF_A_FRAC: rdata_q <= {3'h0, frac_q};
				UBF_A_CFG: rdata_q <= cfg_q;
				UBF_A_CTL: rdata_q <= ctl_q;
				UBF_A_DATA: rdata_q <= rx_data_q;
				UBF_A_STAT: rdata_q <= {1'b0, ir_rate_ok, rx_mark_q,
					rx_ninth_q, rx_perr_q, rx_ferr_q, rx_full_q,
					tx_busy_q};
				default: rdata_q <= 8'h00; // unmapped reads zero
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : ubf_core

//--- bench/ubf_core_sva.sv
// ubf_core_chk: port-level checks on the serial port core
// assumes the register map of ubf_pkg; sees only the core's ports
`timescale 1ns/1ns
module ubf_core_chk import ubf_pkg::*; (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic rxd_i,
	input wire logic txd_i,
	input wire logic txd_o,
	input wire logic txd_oe_n,
	input wire logic tx_busy,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_ninth_bit,
	input wire logic rx_addr_mark,
	input wire logic rx_frame_err,
	input wire logic rx_parity_err
);
	logic [7:0] ctl_q; // shadow of control, gives line polarity
	logic [15:0] bcnt_q; // cycles of the current busy span
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// track control writes as the core takes them
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) ctl_q <= 8'h00;
		else if (reg_wr && reg_addr == UBF_A_CTL) ctl_q <= reg_wdata;
	end
	// busy length, cleared while idle
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) bcnt_q <= 16'h0000;
		else if (tx_busy) bcnt_q <= bcnt_q + 16'h0001;
		else bcnt_q <= 16'h0000;
	end
	a_busy_cause: assert property ($rose(tx_busy) |->
		$past(reg_wr && reg_addr == UBF_A_DATA)) else $error("busy w/o write");
	a_start_low: assert property ($rose(tx_busy) && !ctl_q[UBF_CTL_IR_EN]
		|=> txd_o == ctl_q[UBF_CTL_TX_POLARITY_FLIP]) else $error("start bit level");
	a_frame_min: assert property ($fell(tx_busy) && ctl_q[UBF_CTL_TX_ON]
		|-> bcnt_q >= 16'h00A0) else $error("frame too short");
	a_bit_hold: assert property (tx_busy && !ctl_q[UBF_CTL_IR_EN]
		&& $changed(txd_o) |=> $stable(txd_o) [*8]) else $error("bit too short");
	a_idle_level: assert property (!tx_busy && !$past(tx_busy)
		&& $stable(ctl_q) |-> txd_o == (ctl_q[UBF_CTL_TX_POLARITY_FLIP] ^
		!ctl_q[UBF_CTL_IR_EN])) else $error("idle level");
	a_valid_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("rx valid too long");
	a_rx_hold: assert property (!rx_valid |-> $stable(rx_data)
		&& $stable(rx_ninth_bit)) else $error("rx data moved");
	a_oe_busy: assert property (tx_busy && $past(tx_busy)
		|-> !txd_oe_n) else $error("pin released in frame");
	c_rx: cover property (rx_valid);
	c_tx: cover property ($fell(tx_busy));
	c_ir: cover property (tx_busy && ctl_q[UBF_CTL_IR_EN]);
endmodule : ubf_core_chk
bind ubf_core ubf_core_chk ubf_core_chk_inst (.core_clk, .resetn, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rxd_i, .txd_i, .txd_o,
	.txd_oe_n, .tx_busy, .rx_valid, .rx_data, .rx_ninth_bit, .rx_addr_mark,
	.rx_frame_err, .rx_parity_err);

//--- bench/ubf_peer.sv
// ubf_peer: remote serial device on the far side of the pins
// assumes a fixed bit time in module clock cycles, plain polarity
`timescale 1ns/1ns
module ubf_peer #(
	parameter int BT = 32
) (
	input wire logic core_clk,
	input wire logic line_i,
	output logic line_o
);
	initial line_o = 1'b1; // pulled-up line idles high
	// capture a frame, first wire bit into f[0], sampled mid-bit
	task automatic grab(input int n, output logic [11:0] f);
		int k;
		f = 12'h000;
		k = 0;
		while (line_i !== 1'b0 && k < 4000) begin
			@(negedge core_clk);
			k++;
		end
		repeat (BT / 2) @(negedge core_clk);
		for (int i = 0; i < n; i++) begin
			f[i] = line_i;
			repeat (BT) @(negedge core_clk);
		end
	endtask : grab
	// drive a frame from f[0] upward, then back to idle
	task automatic send(input int n, input logic [11:0] f);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk);
			line_o <= f[i];
			repeat (BT - 1) @(posedge core_clk);
		end
		@(posedge core_clk);
		line_o <= 1'b1;
	endtask : send
endmodule : ubf_peer

//--- bench/test_uart_baud_frame_loop_ir.sv
// test_uart_baud_frame_loop_ir: self-checking bench for ubf_core
// assumes peer model on the pins; divisor 2 gives 32-cycle bits
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_uart_baud_frame_loop_ir import ubf_pkg::*;;
	typedef struct {
		logic [7:0] cfg, ctl, dat;
		int n;
		logic [11:0] fr;
		logic [7:0] rd;
		logic r9, am;
	} ubf_row_t;
	// config, frame on the wire, expected receive results
	ubf_row_t rows [6] = '{
		'{8'h00, 8'h03, 8'hA5, 10, 12'h34A, 8'hA5, 1'b0, 1'b1},
		'{8'h10, 8'h03, 8'h31, 10, 12'h318, 8'h31, 1'b0, 1'b1},
		'{8'h02, 8'h03, 8'h33, 10, 12'h266, 8'h33, 1'b0, 1'b0},
		'{8'h01, 8'h83, 8'h0F, 11, 12'h61E, 8'h0F, 1'b1, 1'b1},
		'{8'h0B, 8'h03, 8'h03, 12, 12'h806, 8'h03, 1'b0, 1'b0},
		'{8'h07, 8'h03, 8'h01, 11, 12'h402, 8'h01, 1'b0, 1'b0}};
	int w [4] = '{1, 2, 6, 8}; // pulse cycles at a 32-cycle bit
	int err_total = 0;
	int checked = 0;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sw = 1'b0; // single-wire: peer talks on the tx wire
	logic [7:0] reg_rdata, rx_data, v;
	logic txd_o, txd_oe_n, tx_busy, rx_valid, rx_ninth_bit, rx_addr_mark;
	logic rx_frame_err, rx_parity_err, p_line, rxd_i, txd_i;
	logic [11:0] f;
	int c, p;
	// wire levels: released tx pin carries the peer or the pull-up
	assign rxd_i = sw ? 1'b1 : p_line;
	assign txd_i = !txd_oe_n ? txd_o : (sw ? p_line : 1'b1);
	always #50 core_clk = ~core_clk;
	ubf_core ubf_core_inst (.core_clk(core_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_i(rxd_i),
		.txd_i(txd_i), .txd_o(txd_o), .txd_oe_n(txd_oe_n),
		.tx_busy(tx_busy), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ninth_bit(rx_ninth_bit), .rx_addr_mark(rx_addr_mark),
		.rx_frame_err(rx_frame_err), .rx_parity_err(rx_parity_err));
	ubf_peer #(.BT(32)) ubf_peer_inst (.core_clk(core_clk),
		.line_i(txd_i), .line_o(p_line));
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		d = reg_rdata;
	endtask : rd
	// bounded wait for the receive pulse
	task automatic wait_rx;
		int k;
		k = 0;
		while (rx_valid !== 1'b1 && k < 3000) begin
			@(negedge core_clk);
			k++;
		end
		`CHK(k < 3000, 1'b1)
	endtask : wait_rx
	// busy cycles, and cycles at the pulse level ~inv
	task automatic busy_len(input logic inv, output int c, output int p);
		c = 0;
		p = 0;
		@(negedge core_clk);
		while (tx_busy === 1'b1 && c < 5000) begin
			c++;
			if (txd_o === ~inv) p++;
			@(negedge core_clk);
		end
	endtask : busy_len
	task summarize;
		if (err_total == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : summarize
	// watchdog: whole run is well under this span
	initial begin
		repeat (60000) @(posedge core_clk);
		err_total++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		rd(UBF_A_CFG, v);
		`CHK(v, UBF_CFG_RST)
		rd(3'h7, v); // unmapped reads zero
		`CHK(v, 8'h00)
		wr(UBF_A_BAUD_HI, 8'h01);
		rd(UBF_A_BAUD_HI, v);
		`CHK(v, 8'h00)
		wr(UBF_A_BAUD_HI, 8'h00);
		wr(UBF_A_BAUD_LO, 8'h02);
		foreach (rows[i]) begin
			wr(UBF_A_CFG, rows[i].cfg);
			wr(UBF_A_CTL, rows[i].ctl);
			wr(UBF_A_DATA, rows[i].dat);
			ubf_peer_inst.grab(rows[i].n, f);
			`CHK(f, rows[i].fr)
			fork
				ubf_peer_inst.send(rows[i].n, rows[i].fr);
				wait_rx();
			join
			`CHK(rx_data, rows[i].rd)
			`CHK(rx_ninth_bit, rows[i].r9)
			`CHK(rx_addr_mark, rows[i].am)
			`CHK({rx_parity_err, rx_frame_err}, 2'b00)
		end
		// ninth bit resent without rewriting control
		wr(UBF_A_CFG, 8'h01);
		wr(UBF_A_CTL, 8'h83);
		repeat (2) begin
			wr(UBF_A_DATA, 8'h0F);
			ubf_peer_inst.grab(11, f);
			`CHK(f, 12'h61E)
		end
		// wrap: receive pin carries a different frame meanwhile
		wr(UBF_A_CFG, 8'h20); // tx and rx both on
		wr(UBF_A_DATA, 8'h3C);
		fork
			ubf_peer_inst.send(10, 12'h200);
			wait_rx();
		join
		`CHK(rx_data, 8'h3C)
		// single wire: peer talks on the released tx pin
		wr(UBF_A_CFG, 8'h60);
		sw <= 1'b1;
		repeat (2) @(negedge core_clk);
		`CHK(txd_oe_n, 1'b1)
		fork
			ubf_peer_inst.send(10, 12'h2B4);
			wait_rx();
		join
		`CHK(rx_data, 8'h5A)
		sw <= 1'b0;
		// infrared widths, both polarities flipped on odd codes; wrapped
		// so the decoder sees the pulses; receiver stays off until the
		// stretch of the mode switch glitch has run out
		wr(UBF_A_CFG, 8'h20);
		for (int i = 0; i < 4; i++) begin
			wr(UBF_A_CTL, 8'h11 | 8'(i << 5) | 8'((i % 2) * 12));
			repeat (40) @(posedge core_clk);
			wr(UBF_A_CTL, 8'h13 | 8'(i << 5) | 8'((i % 2) * 12));
			wr(UBF_A_DATA, 8'h00);
			fork
				busy_len(i[0], c, p);
				wait_rx();
			join
			`CHK(p, 9 * w[i])
			`CHK(rx_data, 8'h00)
		end
		// fraction adds fr/32 of a tick period on average
		wr(UBF_A_CTL, 8'h03);
		wr(UBF_A_BAUD_LO, 8'h01);
		foreach (w[i]) begin
			wr(UBF_A_FRAC, 8'(i * 10));
			wr(UBF_A_DATA, 8'h55);
			busy_len(1'b1, c, p);
			`CHK(c inside {[158 + 50 * i : 162 + 50 * i]}, 1'b1)
		end
		// zero divisor holds the frame until a divisor arrives
		wr(UBF_A_FRAC, 8'h00);
		wr(UBF_A_BAUD_LO, 8'h00);
		wr(UBF_A_DATA, 8'h55);
		repeat (200) @(negedge core_clk);
		`CHK(tx_busy, 1'b1)
		wr(UBF_A_BAUD_LO, 8'h01);
		busy_len(1'b1, c, p);
		`CHK(c inside {[158:162]}, 1'b1)
		summarize();
	end
endmodule : test_uart_baud_frame_loop_ir
